// ==== shared/sys_decode_map.svh ====
// Address windows, reset-cause bit positions and timing counts of the system decoder
`ifndef SYS_DECODE_MAP_SVH
`define SYS_DECODE_MAP_SVH

// ==========================================================
// Memory windows
`define PROG_MEM_LO        32'h0000_0000
`define PROG_MEM_HI        32'h0001_ffff
`define DATA_MEM_LO        32'h2000_0000
`define DATA_MEM_HI        32'h2000_3fff
// ==========================================================
// High-speed controller region
`define HS_REGION_LO       32'h5000_0000
`define HS_REGION_HI       32'h501f_ffff
`define GLOBAL_CTRL_LO     32'h5000_0000
`define GLOBAL_CTRL_HI     32'h5000_01ff
`define CLOCK_CTRL_LO      32'h5000_0200
`define CLOCK_CTRL_HI      32'h5000_02ff
`define IRQ_MUX_LO         32'h5000_0300
`define IRQ_MUX_HI         32'h5000_03ff
`define GPIO_CTRL_LO       32'h5000_4000
`define GPIO_CTRL_HI       32'h5000_7fff
`define PDMA_LO            32'h5000_8000
`define PDMA_HI            32'h5000_bfff
`define FLASH_CTRL_LO      32'h5000_c000
`define FLASH_CTRL_HI      32'h5000_ffff
`define EXT_BUS_LO         32'h5001_0000
`define EXT_BUS_HI         32'h5001_03ff
// ==========================================================
// First peripheral bus
`define PBUS_A_LO          32'h4000_0000
`define PBUS_A_HI          32'h400f_ffff
`define WATCHDOG_LO        32'h4000_4000
`define WATCHDOG_HI        32'h4000_7fff
`define RTC_LO             32'h4000_8000
`define RTC_HI             32'h4000_bfff
`define TIMER_A_LO         32'h4001_0000
`define TIMER_A_HI         32'h4001_3fff
`define TWO_WIRE_A_LO      32'h4002_0000
`define TWO_WIRE_A_HI      32'h4002_3fff
`define SYNC_SER_A_LO      32'h4003_0000
`define SYNC_SER_A_HI      32'h4003_3fff
`define SYNC_SER_B_LO      32'h4003_4000
`define SYNC_SER_B_HI      32'h4003_7fff
`define PULSE_A_LO         32'h4004_0000
`define PULSE_A_HI         32'h4004_3fff
`define SERIAL_A_LO        32'h4005_0000
`define SERIAL_A_HI        32'h4005_3fff
`define FS_DEVICE_LO       32'h4006_0000
`define FS_DEVICE_HI       32'h4006_3fff
`define ADC_LO             32'h400e_0000
`define ADC_HI             32'h400e_ffff
// ==========================================================
// Second peripheral bus
`define PBUS_B_LO          32'h4010_0000
`define PBUS_B_HI          32'h401f_ffff
`define TIMER_B_LO         32'h4011_0000
`define TIMER_B_HI         32'h4011_3fff
`define TWO_WIRE_B_LO      32'h4012_0000
`define TWO_WIRE_B_HI      32'h4012_3fff
`define PULSE_B_LO         32'h4014_0000
`define PULSE_B_HI         32'h4014_3fff
`define SERIAL_B_LO        32'h4015_0000
`define SERIAL_B_HI        32'h4015_3fff
`define SERIAL_C_LO        32'h4015_4000
`define SERIAL_C_HI        32'h4015_7fff
// ==========================================================
// Core system space
`define SYS_TICK_LO        32'he000_e010
`define SYS_TICK_HI        32'he000_e0ff
`define IRQ_CTRL_LO        32'he000_e100
`define IRQ_CTRL_HI        32'he000_ecff
`define SYS_CTRL_BLK_LO    32'he000_ed00
`define SYS_CTRL_BLK_HI    32'he000_ed8f
// ==========================================================
// Reset cause flag positions
`define RC_POWER_ON        0
`define RC_PIN             1
`define RC_WATCHDOG        2
`define RC_LOW_VOLT        3
`define RC_BROWN_OUT       4
`define RC_CPU             5
`define RC_SYSTEM          6
// ==========================================================
// Timing and boot select reset value
`define RESET_STRETCH_CYC  4'h4
`define BOOT_SELECT_RST    1'b0

`endif

// ==== shared/sys_decode_pkg.sv ====
// Types shared by the system decoder and its helpers
package sys_decode_pkg;

   // Target selected by one access
   typedef enum logic [4:0] {
      TGT_NONE,
      TGT_PROG_MEM,
      TGT_DATA_MEM,
      TGT_GLOBAL_CTRL,
      TGT_CLOCK_CTRL,
      TGT_IRQ_MUX,
      TGT_GPIO_CTRL,
      TGT_PDMA,
      TGT_FLASH_CTRL,
      TGT_EXT_BUS,
      TGT_WATCHDOG,
      TGT_RTC,
      TGT_TIMER_A,
      TGT_TWO_WIRE_A,
      TGT_SYNC_SER_A,
      TGT_SYNC_SER_B,
      TGT_PULSE_A,
      TGT_SERIAL_A,
      TGT_FS_DEVICE,
      TGT_ADC,
      TGT_TIMER_B,
      TGT_TWO_WIRE_B,
      TGT_PULSE_B,
      TGT_SERIAL_B,
      TGT_SERIAL_C,
      TGT_SYS_TICK,
      TGT_IRQ_CTRL,
      TGT_SYS_CTRL_BLK
   } target_t;

   localparam int NUM_TARGETS = 28;

   // Processor access request
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        write;
      logic        big_endian;
   } bus_req_t;

   // Decoder answer for one access
   typedef struct packed {
      logic                   valid;
      logic [NUM_TARGETS-1:0] sel;
      logic                   error;
   } bus_rsp_t;

   // Raw reset events, one bit per cause
   typedef struct packed {
      logic system;
      logic cpu;
      logic brown_out;
      logic low_volt;
      logic watchdog;
      logic pin;
      logic power_on;
   } reset_events_t;

   typedef enum {
      RST_RUN,
      RST_HOLD
   } reset_state_t;

endpackage : sys_decode_pkg

// ==== hdl/addr_window_decode.sv ====
// Combinational address-to-target decoder
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_map.svh"

module addr_window_decode
   import sys_decode_pkg::*;
(
   // Address in
   input  wire logic [31:0]            addr_i,
   // Target out
   output sys_decode_pkg::target_t     target_o
);
   import sys_decode_pkg::*;

   function automatic logic in_win(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   // Priority chain gives one target at most
   always_comb begin
      target_o = TGT_NONE;
      if (in_win(addr_i, `PROG_MEM_LO, `PROG_MEM_HI))
         target_o = TGT_PROG_MEM;
      else if (in_win(addr_i, `DATA_MEM_LO, `DATA_MEM_HI))
         target_o = TGT_DATA_MEM;
      else if (in_win(addr_i, `HS_REGION_LO, `HS_REGION_HI)) begin
         if (in_win(addr_i, `GLOBAL_CTRL_LO, `GLOBAL_CTRL_HI))
            target_o = TGT_GLOBAL_CTRL;
         else if (in_win(addr_i, `CLOCK_CTRL_LO, `CLOCK_CTRL_HI))
            target_o = TGT_CLOCK_CTRL;
         else if (in_win(addr_i, `IRQ_MUX_LO, `IRQ_MUX_HI))
            target_o = TGT_IRQ_MUX;
         else if (in_win(addr_i, `GPIO_CTRL_LO, `GPIO_CTRL_HI))
            target_o = TGT_GPIO_CTRL;
         else if (in_win(addr_i, `PDMA_LO, `PDMA_HI))
            target_o = TGT_PDMA;
         else if (in_win(addr_i, `FLASH_CTRL_LO, `FLASH_CTRL_HI))
            target_o = TGT_FLASH_CTRL;
         else if (in_win(addr_i, `EXT_BUS_LO, `EXT_BUS_HI))
            target_o = TGT_EXT_BUS;
      end
      else if (in_win(addr_i, `PBUS_A_LO, `PBUS_A_HI)) begin
         if (in_win(addr_i, `WATCHDOG_LO, `WATCHDOG_HI))
            target_o = TGT_WATCHDOG;
         else if (in_win(addr_i, `RTC_LO, `RTC_HI))
            target_o = TGT_RTC;
         else if (in_win(addr_i, `TIMER_A_LO, `TIMER_A_HI))
            target_o = TGT_TIMER_A;
         else if (in_win(addr_i, `TWO_WIRE_A_LO, `TWO_WIRE_A_HI))
            target_o = TGT_TWO_WIRE_A;
         else if (in_win(addr_i, `SYNC_SER_A_LO, `SYNC_SER_A_HI))
            target_o = TGT_SYNC_SER_A;
         else if (in_win(addr_i, `SYNC_SER_B_LO, `SYNC_SER_B_HI))
            target_o = TGT_SYNC_SER_B;
         else if (in_win(addr_i, `PULSE_A_LO, `PULSE_A_HI))
            target_o = TGT_PULSE_A;
         else if (in_win(addr_i, `SERIAL_A_LO, `SERIAL_A_HI))
            target_o = TGT_SERIAL_A;
         else if (in_win(addr_i, `FS_DEVICE_LO, `FS_DEVICE_HI))
            target_o = TGT_FS_DEVICE;
         else if (in_win(addr_i, `ADC_LO, `ADC_HI))
            target_o = TGT_ADC;
      end
      else if (in_win(addr_i, `PBUS_B_LO, `PBUS_B_HI)) begin
         if (in_win(addr_i, `TIMER_B_LO, `TIMER_B_HI))
            target_o = TGT_TIMER_B;
         else if (in_win(addr_i, `TWO_WIRE_B_LO, `TWO_WIRE_B_HI))
            target_o = TGT_TWO_WIRE_B;
         else if (in_win(addr_i, `PULSE_B_LO, `PULSE_B_HI))
            target_o = TGT_PULSE_B;
         else if (in_win(addr_i, `SERIAL_B_LO, `SERIAL_B_HI))
            target_o = TGT_SERIAL_B;
         else if (in_win(addr_i, `SERIAL_C_LO, `SERIAL_C_HI))
            target_o = TGT_SERIAL_C;
      end
      else if (in_win(addr_i, `SYS_TICK_LO, `SYS_TICK_HI))
         target_o = TGT_SYS_TICK;
      else if (in_win(addr_i, `IRQ_CTRL_LO, `IRQ_CTRL_HI))
         target_o = TGT_IRQ_CTRL;
      else if (in_win(addr_i, `SYS_CTRL_BLK_LO, `SYS_CTRL_BLK_HI))
         target_o = TGT_SYS_CTRL_BLK;
   end

endmodule : addr_window_decode
`default_nettype wire

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_r <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule : pin_sync
`default_nettype wire

// ==== hdl/system_address_decode.sv ====
// System address decoder with reset-cause capture and reset scoping
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_map.svh"

// Functional notes
// - Low 128 KB goes to program memory
// - 16 KB at data base to SRAM
// - High-speed region decoded with sub-windows
// - First 512 bytes select global control
// - Next windows: clock control, interrupt mux
// - GPIO then peripheral DMA, 16 KB each
// - Flash controller 16 KB, external bus 1 KB
// - First peripheral bus: watchdog, real-time clock
// - Timer pair A, two-wire A windows
// - Sync serial A and B adjacent windows
// - Pulse unit A, serial A, device controller
// - ADC owns full 64 KB window
// - Second peripheral bus; timer pair B
// - Two-wire B, pulse B, serial B, C
// - System tick timer sub-range
// - Interrupt controller and system control block
// - Little-endian only; big-endian access errors
// - One sticky flag per reset cause
// - Power-on and system reset clear chip
// - System reset keeps crystal, boot select
module system_address_decode
   import sys_decode_pkg::*;
(
   // Clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_i,
   // Processor access
   input  wire sys_decode_pkg::bus_req_t      req_i,
   output sys_decode_pkg::bus_rsp_t           rsp_o,
   output sys_decode_pkg::target_t            target_o,
   // Reset sources
   input  wire logic                          external_reset_pin_n_i,
   input  wire sys_decode_pkg::reset_events_t reset_events_i,
   input  wire logic                          reset_flags_clear_i,
   input  wire logic [6:0]                    reset_flags_clear_mask_i,
   // Boot select
   input  wire logic                          boot_select_wr_i,
   input  wire logic                          boot_select_wdata_i,
   // Reset scope outputs
   output logic [6:0]                         reset_cause_flags_o,
   output logic                               chip_reset_o,
   output logic                               crystal_reset_o,
   output logic                               boot_select_bit_o
);
   import sys_decode_pkg::*;

   // ==========================================================
   // Input synchronisers
   logic pin_n_sync;
   logic [6:0] events_sync;

   // Pin idles high through the pull-up
   pin_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (external_reset_pin_n_i),
      .sync_o    (pin_n_sync)
   );

   // Reset events come from analog and other domains
   pin_sync #(
      .WIDTH     (7),
      .RESET_VAL (7'h00)
   ) u_evt_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   (reset_events_i),
      .sync_o    (events_sync)
   );

   // ==========================================================
   // Address decode
   target_t target;

   addr_window_decode u_decode (
      .addr_i   (req_i.addr),
      .target_o (target)
   );

   function automatic logic [NUM_TARGETS-1:0] one_hot(input target_t t);
      one_hot = '0;
      if (t != TGT_NONE)
         one_hot[t] = 1'b1;
   endfunction : one_hot

   // Data outputs from flip-flops, answer one cycle after request
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || chip_reset_o) begin
         rsp_o    <= '0;
         target_o <= TGT_NONE;
      end else begin
         rsp_o.valid <= req_i.valid;
         if (req_i.valid && !req_i.big_endian) begin
            rsp_o.sel   <= one_hot(target);
            rsp_o.error <= (target == TGT_NONE);
            target_o    <= target;
         end else begin
            rsp_o.sel   <= '0;
            rsp_o.error <= req_i.valid;
            target_o    <= TGT_NONE;
         end
      end
   end

   // ==========================================================
   // Reset cause capture
   logic [6:0] cause_now;

   always_comb begin
      cause_now = events_sync;
      cause_now[`RC_PIN] = events_sync[`RC_PIN] | ~pin_n_sync;
   end

   // Set wins over clear; survives chip reset so software sees it
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reset_cause_flags_o <= 7'h00;
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (cause_now[i])
               reset_cause_flags_o[i] <= 1'b1;
            else if (reset_flags_clear_i && reset_flags_clear_mask_i[i])
               reset_cause_flags_o[i] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Reset scope sequencer
   reset_state_t state_r;
   logic [3:0]   hold_cnt_r;
   logic         por_seen_r;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r    <= RST_HOLD;
         hold_cnt_r <= `RESET_STRETCH_CYC;
         por_seen_r <= 1'b1;
      end else begin
         case (state_r)
            RST_RUN: begin
               if (|cause_now) begin
                  state_r    <= RST_HOLD;
                  hold_cnt_r <= `RESET_STRETCH_CYC;
                  por_seen_r <= cause_now[`RC_POWER_ON];
               end
            end
            RST_HOLD: begin
               if (|cause_now) begin
                  hold_cnt_r <= `RESET_STRETCH_CYC;
                  por_seen_r <= por_seen_r | cause_now[`RC_POWER_ON];
               end else if (hold_cnt_r != 4'h0) begin
                  hold_cnt_r <= hold_cnt_r - 4'h1;
               end else begin
                  state_r    <= RST_RUN;
                  por_seen_r <= 1'b0;
               end
            end
            default: state_r <= RST_HOLD;
         endcase
      end
   end

   assign chip_reset_o    = (state_r == RST_HOLD);
   assign crystal_reset_o = chip_reset_o && por_seen_r;

   // ==========================================================
   // Boot select: of the resets, cleared only by power-on; software write can also clear it
   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         boot_select_bit_o <= `BOOT_SELECT_RST;
      else if (crystal_reset_o)
         boot_select_bit_o <= `BOOT_SELECT_RST;
      else if (boot_select_wr_i && !chip_reset_o)
         boot_select_bit_o <= boot_select_wdata_i;
   end

endmodule : system_address_decode
`default_nettype wire

// ==== testbench/cpu_bus_model.sv ====
// Processor bus master model issuing decoder accesses
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
   // Clock
   input  wire logic                clk_sys_i,
   // Request out
   output sys_decode_pkg::bus_req_t req_o
);
   import sys_decode_pkg::*;

   initial req_o = '0;

   // One request per edge; valid stays up for back-to-back use
   task automatic access(input logic [31:0] addr, input logic be);
      @(posedge clk_sys_i);
      req_o <= '{valid: 1'b1, addr: addr, write: addr[2], big_endian: be};
   endtask : access

   // Released address inverted so a stale match cannot pass
   task automatic idle();
      @(posedge clk_sys_i);
      req_o <= '{valid: 1'b0, addr: ~req_o.addr, write: 1'b0, big_endian: 1'b0};
   endtask : idle
endmodule : cpu_bus_model
`default_nettype wire

// ==== testbench/system_address_decode_sva.sv ====
// Concurrent checks on the system decoder ports
`timescale 1ns/10ps
`default_nettype none
module system_address_decode_chk (
   // Clock and reset
   input wire logic                          clk_sys_i,
   input wire logic                          reset_i,
   // Processor access
   input wire sys_decode_pkg::bus_req_t      req_i,
   input wire sys_decode_pkg::bus_rsp_t      rsp_o,
   input wire sys_decode_pkg::target_t       target_o,
   // Reset sources
   input wire logic                          external_reset_pin_n_i,
   input wire sys_decode_pkg::reset_events_t reset_events_i,
   input wire logic                          reset_flags_clear_i,
   input wire logic [6:0]                    reset_flags_clear_mask_i,
   input wire logic                          boot_select_wr_i,
   input wire logic                          boot_select_wdata_i,
   // Reset scope
   input wire logic [6:0]                    reset_cause_flags_o,
   input wire logic                          chip_reset_o,
   input wire logic                          crystal_reset_o,
   input wire logic                          boot_select_bit_o
);
   import sys_decode_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic taken;
   assign taken = req_i.valid && !chip_reset_o;

   // ==========================================================
   // Decode
   chk_answer_next: assert property (taken |=> rsp_o.valid || chip_reset_o)
      else $error("no answer one cycle after a request");
   chk_prog_mem: assert property (
      taken && !req_i.big_endian && req_i.addr <= 32'h0001_ffff
      |=> chip_reset_o || target_o == TGT_PROG_MEM)
      else $error("program memory not selected");
   chk_data_mem: assert property (
      taken && !req_i.big_endian && req_i.addr inside {[32'h2000_0000:32'h2000_3fff]}
      |=> chip_reset_o || rsp_o.sel[TGT_DATA_MEM])
      else $error("data memory not selected");
   chk_one_select: assert property (
      rsp_o.valid |-> $onehot0(rsp_o.sel) && (rsp_o.error == (rsp_o.sel == '0)))
      else $error("select not one-hot or error mismatch");
   chk_big_endian: assert property (
      taken && req_i.big_endian |=> chip_reset_o || (rsp_o.error && target_o == TGT_NONE))
      else $error("big-endian access not refused");
   chk_unmapped_err: assert property (
      taken && req_i.addr[31:28] == 4'h3 |=> chip_reset_o || rsp_o.error)
      else $error("unmapped access not refused");
   // ==========================================================
   // Reset scope
   chk_flag_sticky: assert property (
      !$past(reset_flags_clear_i) |-> (reset_cause_flags_o & $past(reset_cause_flags_o))
      == $past(reset_cause_flags_o))
      else $error("cause flag lost without clear");
   chk_pin_flag: assert property (
      $fell(external_reset_pin_n_i) |-> ##[1:4] (reset_cause_flags_o[1] && chip_reset_o))
      else $error("pin low did not reset or flag");
   chk_system_rst: assert property (
      $rose(reset_events_i.system) |-> ##[1:4] (chip_reset_o && reset_cause_flags_o[6]))
      else $error("system event did not reset chip");
   chk_power_on: assert property (
      $rose(reset_events_i.power_on) |-> ##[1:4] (crystal_reset_o && chip_reset_o))
      else $error("power-on event did not reset crystal");
   chk_boot_keep: assert property (
      boot_select_bit_o != $past(boot_select_bit_o)
      |-> $past(boot_select_wr_i) || crystal_reset_o || $past(crystal_reset_o))
      else $error("boot select changed outside write or power-on");
   chk_boot_write: assert property (
      boot_select_wr_i && !chip_reset_o |=> boot_select_bit_o == $past(boot_select_wdata_i))
      else $error("boot select write lost");

   cover property (taken && req_i.big_endian);
   cover property (rsp_o.valid && rsp_o.error);
   cover property ($rose(chip_reset_o) && !crystal_reset_o);
endmodule : system_address_decode_chk

bind system_address_decode system_address_decode_chk i_system_address_decode_chk (.*);
`default_nettype wire

// ==== testbench/tb_system_address_decode.sv ====
// Self-checking bench for the system decoder
`timescale 1ns/10ps
`default_nettype none
module tb_system_address_decode;
   import sys_decode_pkg::*;
   // ==========================================================
   // Signals
   logic          clk_sys_i = 1'b0;
   logic          reset_i = 1'b1;
   bus_req_t      req_i;
   bus_rsp_t      rsp_o;
   target_t       target_o;
   logic          external_reset_pin_n_i = 1'b1;
   reset_events_t reset_events_i = '0;
   logic          reset_flags_clear_i = 1'b0;
   logic [6:0]    reset_flags_clear_mask_i = '0;
   logic          boot_select_wr_i = 1'b0;
   logic          boot_select_wdata_i = 1'b0;
   logic [6:0]    reset_cause_flags_o;
   logic          chip_reset_o;
   logic          crystal_reset_o;
   logic          boot_select_bit_o;
   int            fail_count = 0;
   int            num_checks = 0;
   int            cycles = 0;
   target_t       exp_q[$];
   target_t       exp_t;
   // Unmapped 0x3 page included so unmapped accesses are really driven
   logic [31:0]   base [6] = '{32'h0, 32'h2000_0000, 32'h4000_0000, 32'h5000_0000, 32'he000_e000,
                               32'h3000_0000};
   // Windows in target order, low and high bound
   logic [31:0]   win [1:27][2] = '{
      '{32'h0000_0000, 32'h0001_ffff}, '{32'h2000_0000, 32'h2000_3fff},
      '{32'h5000_0000, 32'h5000_01ff}, '{32'h5000_0200, 32'h5000_02ff},
      '{32'h5000_0300, 32'h5000_03ff}, '{32'h5000_4000, 32'h5000_7fff},
      '{32'h5000_8000, 32'h5000_bfff}, '{32'h5000_c000, 32'h5000_ffff},
      '{32'h5001_0000, 32'h5001_03ff}, '{32'h4000_4000, 32'h4000_7fff},
      '{32'h4000_8000, 32'h4000_bfff}, '{32'h4001_0000, 32'h4001_3fff},
      '{32'h4002_0000, 32'h4002_3fff}, '{32'h4003_0000, 32'h4003_3fff},
      '{32'h4003_4000, 32'h4003_7fff}, '{32'h4004_0000, 32'h4004_3fff},
      '{32'h4005_0000, 32'h4005_3fff}, '{32'h4006_0000, 32'h4006_3fff},
      '{32'h400e_0000, 32'h400e_ffff}, '{32'h4011_0000, 32'h4011_3fff},
      '{32'h4012_0000, 32'h4012_3fff}, '{32'h4014_0000, 32'h4014_3fff},
      '{32'h4015_0000, 32'h4015_3fff}, '{32'h4015_4000, 32'h4015_7fff},
      '{32'he000_e010, 32'he000_e0ff}, '{32'he000_e100, 32'he000_ecff},
      '{32'he000_ed00, 32'he000_ed8f}};

   always #12.5 clk_sys_i = ~clk_sys_i;

   cpu_bus_model i_cpu_bus_model (.clk_sys_i(clk_sys_i), .req_o(req_i));
   system_address_decode i_system_address_decode (.*);

   // ==========================================================
   // Helpers
   function automatic target_t lookup(input logic [31:0] a);
      for (int k = 1; k <= 27; k++) begin
         if (a >= win[k][0] && a <= win[k][1]) return target_t'(k);
      end
      return TGT_NONE;
   endfunction : lookup

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic end_sim();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic go(input logic [31:0] a, input logic be);
      exp_q.push_back(be ? TGT_NONE : lookup(a));
      i_cpu_bus_model.access(a, be);
   endtask : go

   task automatic wait_chip(input logic lvl);
      int n;
      n = 0;
      while (chip_reset_o !== lvl && n < 40) begin
         @(posedge clk_sys_i);
         n++;
      end
      check(chip_reset_o, lvl, "chip reset level");
   endtask : wait_chip

   task automatic ctrl_pulse(input logic [6:0] mask, input logic wr);
      @(posedge clk_sys_i);
      reset_flags_clear_i <= |mask;
      reset_flags_clear_mask_i <= mask;
      boot_select_wr_i <= wr;
      boot_select_wdata_i <= 1'b1;
      @(posedge clk_sys_i);
      reset_flags_clear_i <= 1'b0;
      boot_select_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : ctrl_pulse

   // ==========================================================
   // Answer monitor
   always @(posedge clk_sys_i) begin
      if (rsp_o.valid === 1'b1) begin
         check(exp_q.size() > 0, 1, "unexpected answer");
         exp_t = exp_q.size() > 0 ? exp_q.pop_front() : TGT_NONE;
         check(target_o, exp_t, "target");
         check(rsp_o.sel, exp_t == TGT_NONE ? 0 : 32'h1 << exp_t, "select");
         check(rsp_o.error, exp_t == TGT_NONE, "error");
      end
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("FAIL %0t run too long", $time);
         end_sim();
      end
   end

   // ==========================================================
   // Sequence
   initial begin
      void'($urandom(66));
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      wait_chip(1'b0);
      check(boot_select_bit_o, 0, "boot after power-up");
      // Bounds, one past each bound, a random inside, big-endian
      for (int k = 1; k <= 27; k++) begin
         go(win[k][0], 1'b0);
         go(win[k][1], 1'b0);
         go(win[k][0] - 1, 1'b0);
         go(win[k][1] + 1, 1'b0);
         go(win[k][0] + $urandom_range(win[k][1] - win[k][0]), 1'b0);
         go(win[k][1], 1'b1);
      end
      for (int k = 0; k < 300; k++) go(base[k % 6] | ($urandom & 32'h001f_ffff), 1'b0);
      i_cpu_bus_model.idle();
      repeat (3) @(posedge clk_sys_i);
      check(exp_q.size(), 0, "answers owed");
      // Every reset cause in turn, boot select set beforehand
      for (int k = 0; k < 7; k++) begin
         ctrl_pulse(7'h7f, 1'b1);
         check(boot_select_bit_o, 1, "boot write");
         check(reset_cause_flags_o, 0, "flags cleared");
         if (k == 1) external_reset_pin_n_i <= 1'b0;
         else reset_events_i <= reset_events_t'(7'h01 << k);
         wait_chip(1'b1);
         check(reset_cause_flags_o, 7'h01 << k, "cause flag");
         check(crystal_reset_o, k == 0, "crystal scope");
         // Clear while the cause is still active must lose
         ctrl_pulse(7'h7f, 1'b0);
         check(reset_cause_flags_o, 7'h01 << k, "set beats clear");
         external_reset_pin_n_i <= 1'b1;
         reset_events_i <= '0;
         wait_chip(1'b0);
         check(boot_select_bit_o, k != 0, "boot scope");
         check(reset_cause_flags_o, 7'h01 << k, "sticky flag");
         go(win[k + 1][0], 1'b0);
         i_cpu_bus_model.idle();
      end
      ctrl_pulse(7'h3f, 1'b0);
      check(reset_cause_flags_o, 7'h40, "masked clear");
      ctrl_pulse(7'h40, 1'b0);
      check(reset_cause_flags_o, 0, "clear");
      end_sim();
   end
endmodule : tb_system_address_decode
`default_nettype wire
